// ---- hw/eeprom_host.sv ----
// host controller driving the parallel pins of a paged eeprom module
// How it works
// (R1) read: one select, gate low, strobe high
// (R2) write: select low, gate high, strobe low
// (R3) busy low while programming; poll bit seven
// (R4) hold pin low forces program-reset state
// (R5) never assert both chip selects together
// (R6) page bits constant across one page load
// (R7) byte loads spaced 0.55us min, 30us max
// (R8) strobes idle through load window before programming
// (R9) device programs within 10ms write cycle
// (R10) without busy, wait full write cycle
// (R11) next access after write start delay
// (R12) ignore busy before time to busy
// (R13) no write within hold release time
// (R14) polled bit seven inverted while programming
// (R15) address on strobe fall, data on rise
// (R16) aa,55,a0 prefix enables protection, prefixes writes
// (R17) six-write sequence disables protection, then wait
// (R18) device programs whole buffered page at once
// (R19) busy rises when programming ends
`timescale 1ns/100ps
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int unsigned LOAD_WINDOW_CYCLES = WINDOW_CYC,
  parameter int unsigned PROG_CYCLES        = PROG_CYC,
  parameter int unsigned HOLD_CYCLES        = HOLD_CYC
)
(
  // clock and reset
  input  logic              clock,
  input  logic              rstn,
  // user command port
  input  logic              cmdValid,
  output logic              cmdReady,
  input  cmd_s              cmd,
  input  logic              holdReq,
  // user answers
  output logic              rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic              writeDone,
  output logic              protectOn,
  // memory pins
  output pins_s             pins,
  input  logic [DATA_W-1:0] dataIn,
  input  logic              readyBusy
);

  typedef enum logic [9:0] {
    S_HOLD    = 10'h001,
    S_IDLE    = 10'h002,
    S_READ    = 10'h004,
    S_RECOVER = 10'h008,
    S_WLOW    = 10'h010,
    S_WGAP    = 10'h020,
    S_WINDOW  = 10'h040,
    S_START   = 10'h080,
    S_BUSY    = 10'h100,
    S_LOCK    = 10'h200
  } state_e;

  typedef struct packed {
    state_e           state;
    pins_s            pins;
    cmd_s             pend;
    logic [2:0]       idx;
    logic [2:0]       seqLen;
    logic             protect;
    logic             rspValid;
    logic [31:0]      rspData;
    logic             writeDone;
  } st_s;

  st_s              s_r;
  st_s              s_nxt;
  logic             shortLoad;
  logic [TMR_W-1:0] shortVal;
  logic             shortDone;
  logic             longLoad;
  logic [TMR_W-1:0] longVal;
  logic [TMR_W-1:0] longCount;
  logic             longDone;
  logic [2:0]       total;
  logic             pageOpen;
  step_s            step;

  // the byte load maximum, counted from the window start, decides whether a byte may follow
  localparam int unsigned OPEN_LIMIT = LOAD_WINDOW_CYCLES - LOAD_MAX_CYC;

  function automatic step_s stepOut(op_e op, logic [2:0] idx,
                                    logic [2:0] len, logic [16:0] a,
                                    logic [31:0] d);
    step_s r;
    r.addr = CMD_ADDR_A;
    r.data = {4{CMD_UNLOCK1}};
    if (op == OP_WRITE && idx == len)
    begin
      r.addr = a;
      r.data = d;
    end
    else
    begin
      case (idx)
        3'h1, 3'h4:
        begin
          r.addr = CMD_ADDR_B;
          r.data = {4{CMD_UNLOCK2}};
        end
        3'h2:    r.data = {4{op == OP_PROT_OFF ? CMD_ERASE : CMD_PROTECT}};
        3'h5:    r.data = {4{CMD_RELEASE}};
        default: r.data = {4{CMD_UNLOCK1}};
      endcase
    end
    return r;
  endfunction

  // one chip select per bank, never both
  function automatic logic [1:0] selectBank(logic bank);
    return bank ? 2'h1 : 2'h2; // R5
  endfunction

  cycle_timer u_short (
    .clock   (clock),
    .rstn    (rstn),
    .load    (shortLoad),
    .loadVal (shortVal),
    .count   (),
    .expired (shortDone)
  );

  cycle_timer u_long (
    .clock   (clock),
    .rstn    (rstn),
    .load    (longLoad),
    .loadVal (longVal),
    .count   (longCount),
    .expired (longDone)
  );

  // a further byte joins the open page only on the same page and bank
  assign pageOpen = cmdValid && cmd.op == OP_WRITE
                    && cmd.bank == s_r.pend.bank
                    && cmd.addr[PAGE_MSB:PAGE_LSB]
                       == s_r.pend.addr[PAGE_MSB:PAGE_LSB] // R6
                    && longCount > TMR_W'(OPEN_LIMIT) && !holdReq; // R7

  assign total = s_r.seqLen + ((s_r.pend.op == OP_WRITE) ? 3'h1 : 3'h0);

  always_comb
  begin
    s_nxt           = s_r;
    s_nxt.rspValid  = 1'b0;
    s_nxt.writeDone = 1'b0;
    shortLoad       = 1'b0;
    shortVal        = '0;
    longLoad        = 1'b0;
    longVal         = '0;
    cmdReady        = 1'b0;
    step            = stepOut(cmd.op, 3'h0, 3'h0, cmd.addr, cmd.data);
    case (s_r.state)
      S_HOLD:
      begin
        if (holdReq)
        begin
          s_nxt.pins.holdN = 1'b0; // R4
        end
        else if (!s_r.pins.holdN)
        begin
          s_nxt.pins.holdN = 1'b1;
          longLoad         = 1'b1;
          longVal          = TMR_W'(HOLD_CYCLES); // R13
        end
        else if (longDone)
        begin
          s_nxt.state = S_IDLE;
        end
      end
      S_IDLE:
      begin
        if (holdReq)
        begin
          s_nxt.state      = S_HOLD;
          s_nxt.pins.holdN = 1'b0; // R4
        end
        else if (cmdValid)
        begin
          cmdReady   = 1'b1;
          s_nxt.pend = cmd;
          s_nxt.idx  = 3'h0;
          if (cmd.op == OP_READ)
          begin
            s_nxt.pins.ceN  = selectBank(cmd.bank); // R1
            s_nxt.pins.oeN  = 1'b0;
            s_nxt.pins.addr = cmd.addr;
            shortLoad       = 1'b1;
            shortVal        = TMR_W'(ACC_CYC);
            s_nxt.state     = S_READ;
          end
          else
          begin
            // protected writes carry the unlock prefix
            if (cmd.op == OP_WRITE)
            begin
              s_nxt.seqLen = s_r.protect ? PREFIX_LEN : 3'h0; // R16
            end
            else
            begin
              s_nxt.seqLen = (cmd.op == OP_PROT_ON) ? PREFIX_LEN
                                                    : DISABLE_LEN; // R17
            end
            step = stepOut(cmd.op, 3'h0, s_nxt.seqLen, cmd.addr, cmd.data);
            s_nxt.pins.ceN     = selectBank(cmd.bank);
            s_nxt.pins.oeN     = 1'b1; // R2
            s_nxt.pins.weN     = 1'b0;
            s_nxt.pins.addr    = step.addr;
            s_nxt.pins.dataOut = step.data;
            s_nxt.pins.dataOe  = 1'b1;
            shortLoad          = 1'b1;
            shortVal           = TMR_W'(WP_CYC);
            s_nxt.state        = S_WLOW;
          end
        end
      end
      S_READ:
      begin
        if (shortDone)
        begin
          // during programming bit seven reads back inverted
          s_nxt.rspData  = dataIn; // R14
          s_nxt.rspValid = 1'b1;
          s_nxt.pins.ceN = CE_IDLE;
          s_nxt.pins.oeN = 1'b1;
          shortLoad      = 1'b1;
          shortVal       = TMR_W'(DF_CYC);
          s_nxt.state    = S_RECOVER;
        end
      end
      S_RECOVER:
      begin
        // keeps our drivers off the bus until the device has let go
        if (shortDone)
        begin
          s_nxt.state = S_IDLE;
        end
      end
      S_WLOW:
      begin
        if (shortDone)
        begin
          // data taken on this rising strobe, address stays put
          s_nxt.pins.weN = 1'b1; // R15
          s_nxt.pins.ceN = CE_IDLE;
          shortLoad      = 1'b1;
          shortVal       = TMR_W'(LOAD_MIN_CYC); // R7
          s_nxt.state    = S_WGAP;
        end
      end
      S_WGAP:
      begin
        if (shortDone)
        begin
          s_nxt.pins.dataOe = 1'b0;
          if (s_r.idx + 3'h1 < total)
          begin
            s_nxt.idx = s_r.idx + 3'h1;
            step = stepOut(s_r.pend.op, s_nxt.idx, s_r.seqLen,
                           s_r.pend.addr, s_r.pend.data);
            s_nxt.pins.ceN     = selectBank(s_r.pend.bank);
            s_nxt.pins.weN     = 1'b0;
            s_nxt.pins.addr    = step.addr;
            s_nxt.pins.dataOut = step.data;
            s_nxt.pins.dataOe  = 1'b1;
            shortLoad          = 1'b1;
            shortVal           = TMR_W'(WP_CYC);
            s_nxt.state        = S_WLOW;
          end
          else if (s_r.pend.op == OP_WRITE)
          begin
            longLoad    = 1'b1;
            longVal     = TMR_W'(LOAD_WINDOW_CYCLES); // R8
            s_nxt.state = S_WINDOW;
          end
          else
          begin
            longLoad    = 1'b1;
            longVal     = TMR_W'(PROG_CYCLES); // R16 R17
            s_nxt.state = S_LOCK;
          end
        end
      end
      S_WINDOW:
      begin
        if (longDone)
        begin
          // strobes stayed idle: the device now programs the page
          shortLoad   = 1'b1; // R18
          shortVal    = TMR_W'(WSTART_CYC > BUSY_CYC ? WSTART_CYC
                                                     : BUSY_CYC); // R11 R12
          s_nxt.state = S_START;
        end
        else if (pageOpen)
        begin
          cmdReady   = 1'b1;
          s_nxt.pend = cmd;
          s_nxt.idx  = s_r.seqLen;
          step = stepOut(cmd.op, s_r.seqLen, s_r.seqLen, cmd.addr, cmd.data);
          s_nxt.pins.ceN     = selectBank(cmd.bank);
          s_nxt.pins.weN     = 1'b0;
          s_nxt.pins.addr    = step.addr;
          s_nxt.pins.dataOut = step.data;
          s_nxt.pins.dataOe  = 1'b1;
          shortLoad          = 1'b1;
          shortVal           = TMR_W'(WP_CYC);
          s_nxt.state        = S_WLOW;
        end
      end
      S_START:
      begin
        if (shortDone)
        begin
          longLoad    = 1'b1;
          longVal     = TMR_W'(PROG_CYCLES); // R9
          s_nxt.state = S_BUSY;
        end
      end
      S_BUSY:
      begin
        // the full write cycle is the fallback if busy never rises
        if (readyBusy || longDone) // R3 R19 R10
        begin
          s_nxt.writeDone = 1'b1;
          s_nxt.state     = S_IDLE;
        end
      end
      S_LOCK:
      begin
        if (longDone)
        begin
          s_nxt.protect   = (s_r.pend.op == OP_PROT_ON); // R16 R17
          s_nxt.writeDone = 1'b1;
          s_nxt.state     = S_IDLE;
        end
      end
      default:
      begin
        s_nxt.state = S_HOLD;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_r            <= '0;
      s_r.state      <= S_HOLD;
      s_r.pins.ceN   <= CE_IDLE;
      s_r.pins.oeN   <= 1'b1;
      s_r.pins.weN   <= 1'b1;
      s_r.pend.op    <= OP_READ;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pins      = s_r.pins;
  assign rspValid  = s_r.rspValid;
  assign rspData   = s_r.rspData;
  assign writeDone = s_r.writeDone;
  assign protectOn = s_r.protect;

endmodule

// ---- hw/eeprom_host_pkg.sv ----
// shared constants and types for the eeprom host controller
package eeprom_host_pkg;

  // clock period and speed grade (1: faster grade, 0: slower grade)
  localparam int CLK_NS     = 8;
  localparam bit FAST_GRADE = 1'b1;

  // documented times in ns, both grades
  localparam int LOAD_MIN_FAST_NS = 550;       // byte_load_interval min
  localparam int LOAD_MIN_SLOW_NS = 950;
  localparam int LOAD_MAX_NS      = 30000;     // byte_load_interval max
  localparam int WINDOW_FAST_NS   = 100000;    // load_window_time
  localparam int WINDOW_SLOW_NS   = 200000;
  localparam int PROG_NS          = 10000000;  // program_cycle_time
  localparam int BUSY_FAST_NS     = 120;       // time_to_busy
  localparam int BUSY_SLOW_NS     = 170;
  localparam int WSTART_FAST_NS   = 150;       // write_start_delay
  localparam int WSTART_SLOW_NS   = 250;
  localparam int HOLD_FAST_NS     = 100000;    // hold_release_to_write
  localparam int HOLD_SLOW_NS     = 200000;
  localparam int WP_FAST_NS       = 250;       // write pulse width
  localparam int WP_SLOW_NS       = 350;
  localparam int ACC_FAST_NS      = 150;       // read access time
  localparam int ACC_SLOW_NS      = 200;
  localparam int DF_FAST_NS       = 50;        // output float time
  localparam int DF_SLOW_NS       = 60;

  // cycle counts: all times round up except the byte load maximum, which rounds down
  localparam int LOAD_MIN_CYC =
    ((FAST_GRADE ? LOAD_MIN_FAST_NS : LOAD_MIN_SLOW_NS) + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_MAX_CYC = LOAD_MAX_NS / CLK_NS;
  localparam int WINDOW_CYC   =
    ((FAST_GRADE ? WINDOW_FAST_NS : WINDOW_SLOW_NS) + CLK_NS - 1) / CLK_NS;
  localparam int PROG_CYC     = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC     =
    ((FAST_GRADE ? BUSY_FAST_NS : BUSY_SLOW_NS) + CLK_NS - 1) / CLK_NS;
  localparam int WSTART_CYC   =
    ((FAST_GRADE ? WSTART_FAST_NS : WSTART_SLOW_NS) + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC     =
    ((FAST_GRADE ? HOLD_FAST_NS : HOLD_SLOW_NS) + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC       =
    ((FAST_GRADE ? WP_FAST_NS : WP_SLOW_NS) + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC      =
    ((FAST_GRADE ? ACC_FAST_NS : ACC_SLOW_NS) + CLK_NS - 1) / CLK_NS;
  localparam int DF_CYC       =
    ((FAST_GRADE ? DF_FAST_NS : DF_SLOW_NS) + CLK_NS - 1) / CLK_NS;

  // widths and field positions
  localparam int TMR_W     = 21;
  localparam int ADDR_W    = 17;
  localparam int DATA_W    = 32;
  localparam int PAGE_LSB  = 7;
  localparam int PAGE_MSB  = 16;

  // protection command addresses and bytes
  localparam logic [16:0] CMD_ADDR_A  = 17'h05555;
  localparam logic [16:0] CMD_ADDR_B  = 17'h02aaa;
  localparam logic [7:0]  CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_PROTECT = 8'ha0;
  localparam logic [7:0]  CMD_ERASE   = 8'h80;
  localparam logic [7:0]  CMD_RELEASE = 8'h20;
  localparam logic [2:0]  PREFIX_LEN  = 3'h3;
  localparam logic [2:0]  DISABLE_LEN = 3'h6;

  // pin levels at reset
  localparam logic [1:0] CE_IDLE = 2'h3;

  typedef enum logic [1:0] {
    OP_READ     = 2'h0,
    OP_WRITE    = 2'h1,
    OP_PROT_ON  = 2'h2,
    OP_PROT_OFF = 2'h3
  } op_e;

  typedef struct packed {
    op_e              op;
    logic             bank;
    logic [16:0]      addr;
    logic [31:0]      data;
  } cmd_s;

  typedef struct packed {
    logic [1:0]       ceN;
    logic             oeN;
    logic             weN;
    logic             holdN;
    logic [16:0]      addr;
    logic [31:0]      dataOut;
    logic             dataOe;
  } pins_s;

  typedef struct packed {
    logic [16:0]      addr;
    logic [31:0]      data;
  } step_s;

endpackage

// ---- hw/cycle_timer.sv ----
// loadable down counter used for all pin timing
`timescale 1ns/100ps
module cycle_timer
  import eeprom_host_pkg::*;
(
  // clock and reset
  input  logic             clock,
  input  logic             rstn,
  // load request
  input  logic             load,
  input  logic [TMR_W-1:0] loadVal,
  // state
  output logic [TMR_W-1:0] count,
  output logic             expired
);

  typedef struct packed {
    logic [TMR_W-1:0] count;
  } tmr_s;

  tmr_s s_r;
  tmr_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (load)
    begin
      s_nxt.count = loadVal;
    end
    else if (s_r.count != '0)
    begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign count   = s_r.count;
  assign expired = (s_r.count == '0);

endmodule

// ---- sim/eeprom_host_properties.sv ----
// port checks for the eeprom host controller
`timescale 1ns/100ps
module eeprom_host_properties
  import eeprom_host_pkg::*;
#(
  parameter int unsigned LOAD_WINDOW_CYCLES = WINDOW_CYC,
  parameter int unsigned PROG_CYCLES        = PROG_CYC,
  parameter int unsigned HOLD_CYCLES        = HOLD_CYC
)
(
  // clock and reset
  input logic              clock,
  input logic              rstn,
  // user side
  input logic              cmdValid,
  input logic              cmdReady,
  input cmd_s              cmd,
  input logic              holdReq,
  input logic              rspValid,
  input logic [DATA_W-1:0] rspData,
  input logic              writeDone,
  input logic              protectOn,
  // memory side
  input pins_s             pins,
  input logic [DATA_W-1:0] dataIn,
  input logic              readyBusy
);
  int   sinceFall;
  int   sinceRise;
  int   holdCnt;
  op_e  lastOp;
  logic weDly;

  // plain int counters; a run is far too short to wrap them
  always_ff @(posedge clock)
  begin
    weDly <= pins.weN;
    if (!rstn)
    begin
      sinceFall <= 1 << 20;
      sinceRise <= 0;
      holdCnt   <= 0;
      lastOp    <= OP_READ;
    end
    else
    begin
      sinceFall <= (weDly && !pins.weN) ? 0 : sinceFall + 1;
      sinceRise <= (!weDly && pins.weN) ? 0 : sinceRise + 1;
      holdCnt   <= pins.holdN ? holdCnt + 1 : 0;
      if (cmdValid && cmdReady)
        lastOp <= cmd.op;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_one_select: assert property (pins.ceN != 2'h0)
    else $error("both chip selects low");
  a_load_spacing: assert property ($fell(pins.weN) |->
    sinceFall >= LOAD_MIN_CYC - 1)
    else $error("strobes closer than the byte load interval");
  a_strobe_steady: assert property (!pins.weN && !$past(pins.weN) |->
    $stable(pins.addr) && $stable(pins.dataOut))
    else $error("address or data moved under the strobe");
  a_write_gate: assert property (!pins.weN |-> pins.oeN && pins.dataOe)
    else $error("strobe low with gate low or bus undriven");
  a_write_settle: assert property (writeDone && lastOp == OP_WRITE |->
    sinceRise >= LOAD_WINDOW_CYCLES + WSTART_CYC)
    else $error("write finished before window and start delay");
  a_prot_wait: assert property (writeDone && lastOp[1] |->
    sinceRise >= PROG_CYCLES - 1)
    else $error("protection op finished before the write cycle");
  a_prot_source: assert property ($changed(protectOn) |->
    lastOp[1] && protectOn == (lastOp == OP_PROT_ON))
    else $error("protection flag moved without its command");
  a_hold_follow: assert property (holdReq |=> !pins.holdN)
    else $error("hold request not passed to the hold pin");
  a_hold_release: assert property ($fell(pins.weN) |->
    holdCnt >= HOLD_CYCLES)
    else $error("write too soon after hold release");

  c_write: cover property (writeDone && lastOp == OP_WRITE);
  c_read: cover property (rspValid);
  c_protect: cover property ($rose(protectOn));
endmodule

bind eeprom_host eeprom_host_properties #(
  .LOAD_WINDOW_CYCLES(LOAD_WINDOW_CYCLES),
  .PROG_CYCLES(PROG_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES)
) props_u (
  .clock(clock), .rstn(rstn), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .cmd(cmd), .holdReq(holdReq), .rspValid(rspValid), .rspData(rspData),
  .writeDone(writeDone), .protectOn(protectOn), .pins(pins),
  .dataIn(dataIn), .readyBusy(readyBusy)
);

// ---- sim/eeprom_model.sv ----
// behavioural model of the paged eeprom module
`timescale 1ns/100ps
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter int WIN = 4000
)
(
  // clock and pacing
  input  logic              clock,
  input  logic              slow,
  // pins from the host
  input  pins_s             pins,
  // device outputs
  output logic [DATA_W-1:0] dataIn,
  output logic              readyBusy
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] pageBuf [int];
  logic [47:0]       hist = 48'h0;
  logic [47:0]       histNxt;
  logic [17:0]       key = 18'h0;
  logic [17:0]       rKey;
  logic              isCmd;
  logic              weLast = 1'b1;
  logic              prot = 1'b0;
  logic              unlocked = 1'b0;
  logic              loading = 1'b0;
  logic [7:0]        lastByte = 8'h0;
  int                idle = 0;
  int                busyCnt = 0;
  int                progCount = 0;

  initial
  begin
    dataIn = 32'h0;
    readyBusy = 1'b1;
  end

  always @(posedge clock)
  begin
    weLast <= pins.weN;
    rKey = {~pins.ceN[1], pins.addr};
    if (!pins.holdN)
    begin
      readyBusy <= 1'b1;
      loading <= 1'b0;
      busyCnt <= 0;
      pageBuf.delete();
    end
    else
    begin
      if (weLast && !pins.weN && pins.ceN != 2'h3 && pins.oeN)
        key <= rKey;
      if (!weLast && pins.weN && pins.oeN)
      begin
        histNxt = {hist[39:0], pins.dataOut[7:0]};
        isCmd = key[16:0] == CMD_ADDR_A || key[16:0] == CMD_ADDR_B;
        hist <= histNxt;
        lastByte <= pins.dataOut[7:0];
        loading <= 1'b1;
        idle <= 0;
        readyBusy <= 1'b0;
        if (histNxt[23:0] == 24'haa55a0)
        begin
          prot <= 1'b1;
          unlocked <= 1'b1;
        end
        else if (histNxt == 48'haa5580aa5520)
        begin
          prot <= 1'b0;
          loading <= 1'b0;
          busyCnt <= slow ? 300 : 60;
        end
        else if (!isCmd && (!prot || unlocked))
          pageBuf[key] = pins.dataOut;
      end
      else if (loading)
      begin
        idle <= idle + 1;
        if (idle == WIN)
        begin
          loading <= 1'b0;
          busyCnt <= slow ? 300 : 60;
        end
      end
      else if (busyCnt > 1)
        busyCnt <= busyCnt - 1;
      else if (busyCnt == 1)
      begin
        foreach (pageBuf[k])
          mem[k] = pageBuf[k];
        pageBuf.delete();
        busyCnt <= 0;
        readyBusy <= 1'b1;
        unlocked <= 1'b0;
        progCount <= progCount + 1;
      end
    end
    // a released bus shows the inverse, never a stale value
    if (pins.holdN && pins.ceN != 2'h3 && !pins.oeN && pins.weN)
      dataIn <= (busyCnt != 0 || loading) ?
        {dataIn[31:8], ~lastByte[7], dataIn[6:0]} :
        (mem.exists(rKey) ? mem[rKey] : 32'hffffffff);
    else
      dataIn <= ~dataIn;
  end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the eeprom host controller
`timescale 1ns/100ps
module testbench;
  import eeprom_host_pkg::*;
  localparam int WIN = 4000;
  logic              clock;
  logic              rstn;
  logic              cmdValid;
  logic              cmdReady;
  cmd_s              cmd;
  logic              holdReq;
  logic              rspValid;
  logic [DATA_W-1:0] rspData;
  logic              writeDone;
  logic              protectOn;
  pins_s             pins;
  logic [DATA_W-1:0] dataIn;
  logic              readyBusy;
  logic              slow;
  logic [DATA_W-1:0] got;
  int                failures;
  int                n_checks;
  int                cycles;
  int                pc;

  // window kept above the page join limit so joining stays on
  eeprom_host #(
    .LOAD_WINDOW_CYCLES(WIN),
    .PROG_CYCLES(400),
    .HOLD_CYCLES(50)
  ) dut_u (
    .clock(clock), .rstn(rstn), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmd(cmd), .holdReq(holdReq), .rspValid(rspValid), .rspData(rspData),
    .writeDone(writeDone), .protectOn(protectOn), .pins(pins),
    .dataIn(dataIn), .readyBusy(readyBusy)
  );

  eeprom_model #(.WIN(WIN)) model_u (
    .clock(clock), .slow(slow), .pins(pins), .dataIn(dataIn),
    .readyBusy(readyBusy)
  );

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      end_sim;
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task issue(input op_e op, input logic bk, input logic [16:0] a,
             input logic [31:0] d);
    int i;
    @(negedge clock);
    cmd = '{op, bk, a, d};
    cmdValid = 1'b1;
    #1;
    for (i = 0; i < 9000 && cmdReady !== 1'b1; i++)
    begin
      @(negedge clock);
      #1;
    end
    @(negedge clock);
    cmdValid = 1'b0;
  endtask

  task wait_done;
    int i;
    for (i = 0; i < 9000 && writeDone !== 1'b1 && rspValid !== 1'b1; i++)
      @(negedge clock);
    got = rspData;
    chk("answer", {31'h0, writeDone | rspValid}, 32'h1);
  endtask

  task read_chk(input logic bk, input logic [16:0] a, input logic [31:0] d);
    issue(OP_READ, bk, a, 32'h0);
    wait_done;
    chk("read data", got, d);
  endtask

  task wr(input logic bk, input logic [16:0] a, input logic [31:0] d);
    issue(OP_WRITE, bk, a, d);
    wait_done;
    read_chk(bk, a, d);
  endtask

  task t_reset;
    chk("holdN in reset", pins.holdN, 1'b0);
    chk("selects in reset", pins.ceN, CE_IDLE);
    chk("ready in reset", cmdReady, 1'b0);
  endtask

  task t_basic;
    wr(1'b0, 17'h00123, 32'hdeadbeef);
    slow = 1'b1;
    wr(1'b0, 17'h01a80, 32'h0badf00d);
    slow = 1'b0;
    read_chk(1'b0, 17'h1ffff, 32'hffffffff);
  endtask

  task t_page;
    pc = model_u.progCount;
    issue(OP_WRITE, 1'b0, 17'h00200, 32'h11223344);
    issue(OP_WRITE, 1'b0, 17'h0027f, 32'h55667788);
    wait_done;
    chk("program cycles", model_u.progCount - pc, 32'h1);
    read_chk(1'b0, 17'h00200, 32'h11223344);
    read_chk(1'b0, 17'h0027f, 32'h55667788);
  endtask

  task t_bank;
    wr(1'b1, 17'h00123, 32'hcafe0001);
    read_chk(1'b0, 17'h00123, 32'hdeadbeef);
  endtask

  task t_hold;
    // hold is only taken from idle, so let read recovery finish first
    repeat (DF_CYC + 2) @(negedge clock);
    holdReq = 1'b1;
    repeat (2) @(negedge clock);
    chk("hold pin", pins.holdN, 1'b0);
    chk("ready in hold", cmdReady, 1'b0);
    holdReq = 1'b0;
    read_chk(1'b1, 17'h00123, 32'hcafe0001);
  endtask

  task t_protect;
    issue(OP_PROT_ON, 1'b0, 17'h0, 32'h0);
    wait_done;
    @(negedge clock);
    chk("protect flag", protectOn, 1'b1);
    chk("device protected", model_u.prot, 1'b1);
    wr(1'b0, 17'h00300, 32'h13579bdf);
    issue(OP_PROT_OFF, 1'b0, 17'h0, 32'h0);
    wait_done;
    @(negedge clock);
    chk("protect flag", protectOn, 1'b0);
    chk("device protected", model_u.prot, 1'b0);
    wr(1'b0, 17'h00301, 32'h2468ace0);
  endtask

  initial
  begin
    failures = 0;
    n_checks = 0;
    cycles = 0;
    rstn = 1'b0;
    cmdValid = 1'b0;
    cmd = '0;
    holdReq = 1'b0;
    slow = 1'b0;
    repeat (20) @(negedge clock);
    t_reset;
    rstn = 1'b1;
    t_basic;
    t_page;
    t_bank;
    t_hold;
    t_protect;
    end_sim;
  end
endmodule
